/* File: rtl/scas_pkg.sv */
// constants shared by the smart card activation sequencer and its clock divider
// assumes a single 10 MHz system clock; oscillator input sampled as a plain level
package scas_pkg;
  localparam int unsigned CLOCK_HZ = 10_000_000;
  localparam int unsigned POWERUP_WAIT_MS = 10;
  localparam int unsigned POWERUP_WAIT_CYCLES = (POWERUP_WAIT_MS * (CLOCK_HZ / 1000));
  localparam int unsigned POWERUP_CNT_W = 17;
  // interval length in oscillator rising edges, one value for every step
  localparam logic [7:0] INTERVAL_TICKS = 8'h10;
  // card clock ratio select codes {hi, lo}
  localparam logic [1:0] RATIO_DIV6 = 2'h0;
  localparam logic [1:0] RATIO_DIV4 = 2'h1;
  localparam logic [1:0] RATIO_DIV1 = 2'h2;
  localparam logic [1:0] RATIO_DIV2 = 2'h3;
  // oscillator edges per half period of the card clock
  localparam logic [1:0] HALF_DIV6 = 2'h3;
  localparam logic [1:0] HALF_DIV4 = 2'h2;
  localparam logic [1:0] HALF_DIV2 = 2'h1;
  typedef enum logic [3:0] {
    SEQ_IDLE, SEQ_RAMP, SEQ_IO_WAIT, SEQ_CLK_WAIT, SEQ_RST_FALL, SEQ_ACTIVE,
    SEQ_D_RST, SEQ_D_CLK, SEQ_D_IO, SEQ_D_VCC
  } scas_seq_type;
  typedef enum logic [1:0] {IO_NEUTRAL, IO_CARD_IN, IO_HOST_IN} scas_io_type;
endpackage : scas_pkg

/* File: rtl/scas_clk_if.sv */
// link between the sequencer and the card clock divider
// assumes both ends share the system clock
`timescale 1ns/1ps
interface scas_clk_if;
  logic [1:0] ratio;
  logic clkRun;
  logic oscTick;
  logic cardClk;
  modport ctrl (output ratio, output clkRun, input oscTick, input cardClk);
  modport div (input ratio, input clkRun, output oscTick, output cardClk);
endinterface : scas_clk_if

/* File: rtl/scas_clk_div.sv */
// card clock divider fed by the sampled oscillator level
// assumes osc_input is synchronous to clock and well below half its rate
`timescale 1ns/1ps
module scas_clk_div (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic oscIn,
  scas_clk_if.div link
);
  logic oscPrev_reg;
  logic [1:0] edgeCnt_reg;
  logic [1:0] halfLen;

  always_comb begin
    unique case (link.ratio)
      scas_pkg::RATIO_DIV6: halfLen = scas_pkg::HALF_DIV6;
      scas_pkg::RATIO_DIV4: halfLen = scas_pkg::HALF_DIV4;
      default: halfLen = scas_pkg::HALF_DIV2;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oscPrev_reg <= 1'b0;
      link.oscTick <= 1'b0;
    end else begin
      oscPrev_reg <= oscIn;
      link.oscTick <= oscIn & ~oscPrev_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      edgeCnt_reg <= 2'h0;
      link.cardClk <= 1'b0;
    end else if (!link.clkRun) begin
      // stopped clock parks low at once, so a high phase in progress is cut short
      edgeCnt_reg <= 2'h0;
      link.cardClk <= 1'b0;
    end else if (link.ratio == scas_pkg::RATIO_DIV1) begin
      edgeCnt_reg <= 2'h0;
      link.cardClk <= oscIn;
    end else if (link.oscTick) begin
      if (edgeCnt_reg + 2'h1 >= halfLen) begin
        edgeCnt_reg <= 2'h0;
        link.cardClk <= ~link.cardClk;
      end else begin
        edgeCnt_reg <= edgeCnt_reg + 2'h1;
      end
    end
  end
endmodule : scas_clk_div

/* File: rtl/scas_sequencer.sv */
// activation and deactivation sequencer for one asynchronous smart card slot
// assumes all inputs synchronous to clock; supervisor and fault detectors are external
`timescale 1ns/1ps

// Overview of operation
// - power request going low starts a card activation
// - card reset copies host reset only when the sequencer allows it
// - voltage select high gives 5V supply, low gives 3V
// - with power request high status shows only card presence, low means no card
// - in a session any fault pulls status low and starts deactivation
// - supply supervisor restarts the power-up hold-off and forces deactivation when low
// - ratio selects 00 /6, 01 /4, 10 undivided, 11 /2
// - activation requests ignored for 10ms after logic supply becomes good
// - activation on request falling edge, card present, no supply fault
// - card supply checked after first interval; if bad, report and power off
// - host reset low: I/O at second interval, clock at third, then reset follows
// - host reset high: clock starts on its falling edge, then reset follows
// - deactivate on request high, overcurrent, supply faults, or card removal
// - deactivation: reset, clock, I/O, supply, one interval each
// - first line to fall becomes input, the other is driven
// - input line rising returns both lines to neutral
module scas_sequencer #(
  parameter int unsigned POWERUP_WAIT_CYCLES = scas_pkg::POWERUP_WAIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic card_power_request_n,
  input wire logic host_reset_in,
  input wire logic card_voltage_select,
  input wire logic clock_ratio_sel_hi,
  input wire logic clock_ratio_sel_lo,
  input wire logic osc_input,
  input wire logic cardPresent,
  input wire logic logicSupplyOk,
  input wire logic cardSupplyValid,
  input wire logic overCurrent,
  input wire logic cardIoIn,
  output logic cardIoOut,
  output logic cardIoOe,
  input wire logic host_io_line_in,
  output logic host_io_line_out,
  output logic host_io_line_oe,
  output logic statusIntNOut,
  output logic statusIntNOe,
  output logic cardSupplyEn,
  output logic cardSupply5v,
  output logic cardClock,
  output logic cardReset
);
  scas_clk_if clkLink ();
  scas_pkg::scas_seq_type seq_reg;
  scas_pkg::scas_seq_type seqPrev_reg;
  scas_pkg::scas_io_type io_reg;
  logic [scas_pkg::POWERUP_CNT_W-1:0] waitCnt_reg;
  logic [7:0] tickCnt_reg;
  logic reqPrev_reg;
  logic hostRstPrev_reg;
  logic rstLowAtStart_reg;
  logic faultLatch_reg;
  logic rstPass_reg;
  logic ioRx_reg;
  logic cardIoPrev_reg;
  logic hostIoPrev_reg;
  logic powerupDone;
  logic intervalDone;
  logic inSession;
  logic faultNow;
  logic startReq;

  scas_clk_div clockDivider (
    .clock(clock),
    .rst_n(rst_n),
    .oscIn(osc_input),
    .link(clkLink)
  );

  assign clkLink.ratio = {clock_ratio_sel_hi, clock_ratio_sel_lo};
  assign clkLink.clkRun = (seq_reg == scas_pkg::SEQ_ACTIVE) || (seq_reg == scas_pkg::SEQ_D_RST)
    || (seq_reg == scas_pkg::SEQ_D_CLK && !intervalDone);
  assign cardClock = clkLink.cardClk;

  assign powerupDone = (waitCnt_reg == scas_pkg::POWERUP_CNT_W'(POWERUP_WAIT_CYCLES));
  // interval end
  // no interval may end in the cycle a step begins, so every step gets a full interval
  assign intervalDone = clkLink.oscTick && (seq_reg == seqPrev_reg)
    && (tickCnt_reg + 8'h01 >= scas_pkg::INTERVAL_TICKS);
  assign inSession = (seq_reg != scas_pkg::SEQ_IDLE) && !card_power_request_n;
  assign faultNow = overCurrent || !logicSupplyOk || !cardPresent
    || (cardSupplyEn && seq_reg != scas_pkg::SEQ_RAMP && !cardSupplyValid);
  assign startReq = reqPrev_reg && !card_power_request_n && powerupDone && cardPresent && logicSupplyOk;

  // power-up hold-off, restarted whenever the supervisor drops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt_reg <= '0;
    end else if (!logicSupplyOk) begin
      waitCnt_reg <= '0;
    end else if (!powerupDone) begin
      waitCnt_reg <= waitCnt_reg + scas_pkg::POWERUP_CNT_W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reqPrev_reg <= 1'b1;
      hostRstPrev_reg <= 1'b0;
      seqPrev_reg <= scas_pkg::SEQ_IDLE;
    end else begin
      reqPrev_reg <= card_power_request_n;
      hostRstPrev_reg <= host_reset_in;
      seqPrev_reg <= seq_reg;
    end
  end

  // interval counter restarts on every state change; a fault exit would otherwise inherit a partial count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_reg <= 8'h00;
    end else if (seq_reg == scas_pkg::SEQ_IDLE || seq_reg != seqPrev_reg || intervalDone) begin
      tickCnt_reg <= 8'h00;
    end else if (clkLink.oscTick) begin
      tickCnt_reg <= tickCnt_reg + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg <= scas_pkg::SEQ_IDLE;
      cardSupplyEn <= 1'b0;
      cardSupply5v <= 1'b0;
      rstPass_reg <= 1'b0;
      ioRx_reg <= 1'b0;
      rstLowAtStart_reg <= 1'b0;
    end else begin
      unique case (seq_reg)
        scas_pkg::SEQ_IDLE: begin
          if (startReq) begin
            seq_reg <= scas_pkg::SEQ_RAMP;
            cardSupplyEn <= 1'b1;
            cardSupply5v <= card_voltage_select;
            rstLowAtStart_reg <= !host_reset_in;
          end
        end
        scas_pkg::SEQ_RAMP: begin
          if (faultNow || card_power_request_n) begin
            seq_reg <= scas_pkg::SEQ_D_VCC;
          end else if (intervalDone) begin
            if (!cardSupplyValid) begin
              cardSupplyEn <= 1'b0;
              seq_reg <= scas_pkg::SEQ_IDLE;
            end else if (rstLowAtStart_reg) begin
              seq_reg <= scas_pkg::SEQ_IO_WAIT;
            end else begin
              ioRx_reg <= 1'b1;
              seq_reg <= scas_pkg::SEQ_RST_FALL;
            end
          end
        end
        scas_pkg::SEQ_IO_WAIT: begin
          if (faultNow || card_power_request_n) begin
            seq_reg <= scas_pkg::SEQ_D_IO;
          end else if (intervalDone) begin
            ioRx_reg <= 1'b1;
            seq_reg <= scas_pkg::SEQ_CLK_WAIT;
          end
        end
        scas_pkg::SEQ_CLK_WAIT: begin
          if (faultNow || card_power_request_n) begin
            seq_reg <= scas_pkg::SEQ_D_IO;
          end else if (intervalDone) begin
            rstPass_reg <= 1'b1;
            seq_reg <= scas_pkg::SEQ_ACTIVE;
          end
        end
        scas_pkg::SEQ_RST_FALL: begin
          if (faultNow || card_power_request_n) begin
            seq_reg <= scas_pkg::SEQ_D_IO;
          end else if (hostRstPrev_reg && !host_reset_in) begin
            rstPass_reg <= 1'b1;
            seq_reg <= scas_pkg::SEQ_ACTIVE;
          end
        end
        scas_pkg::SEQ_ACTIVE: begin
          if (faultNow || card_power_request_n) begin
            seq_reg <= scas_pkg::SEQ_D_RST;
          end
        end
        scas_pkg::SEQ_D_RST: begin
          if (intervalDone) begin
            rstPass_reg <= 1'b0;
            seq_reg <= scas_pkg::SEQ_D_CLK;
          end
        end
        scas_pkg::SEQ_D_CLK: begin
          if (intervalDone) begin
            seq_reg <= scas_pkg::SEQ_D_IO;
          end
        end
        scas_pkg::SEQ_D_IO: begin
          if (intervalDone) begin
            ioRx_reg <= 1'b0;
            seq_reg <= scas_pkg::SEQ_D_VCC;
          end
        end
        scas_pkg::SEQ_D_VCC: begin
          if (intervalDone) begin
            cardSupplyEn <= 1'b0;
            seq_reg <= scas_pkg::SEQ_IDLE;
          end
        end
        default: seq_reg <= scas_pkg::SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cardReset <= 1'b0;
    end else begin
      cardReset <= rstPass_reg && host_reset_in;
    end
  end

  // fault latch; set wins over the end-of-session clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      faultLatch_reg <= 1'b0;
    end else if (inSession && (faultNow || (seq_reg == scas_pkg::SEQ_RAMP && intervalDone && !cardSupplyValid))) begin
      faultLatch_reg <= 1'b1;
    end else if (card_power_request_n) begin
      faultLatch_reg <= 1'b0;
    end
  end

  // presence while request is high, fault latch while it is low; pin is open drain, only ever pulled low
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      statusIntNOut <= 1'b0;
      statusIntNOe <= 1'b1;
    end else begin
      statusIntNOut <= 1'b0;
      statusIntNOe <= card_power_request_n ? !cardPresent : faultLatch_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cardIoPrev_reg <= 1'b1;
      hostIoPrev_reg <= 1'b1;
    end else begin
      cardIoPrev_reg <= cardIoIn;
      hostIoPrev_reg <= host_io_line_in;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      io_reg <= scas_pkg::IO_NEUTRAL;
    end else if (!ioRx_reg) begin
      io_reg <= scas_pkg::IO_NEUTRAL;
    end else begin
      unique case (io_reg)
        scas_pkg::IO_NEUTRAL: begin
          if (cardIoPrev_reg && !cardIoIn) begin
            io_reg <= scas_pkg::IO_CARD_IN;
          end else if (hostIoPrev_reg && !host_io_line_in) begin
            io_reg <= scas_pkg::IO_HOST_IN;
          end
        end
        scas_pkg::IO_CARD_IN: begin
          if (!cardIoPrev_reg && cardIoIn) begin
            io_reg <= scas_pkg::IO_NEUTRAL;
          end
        end
        scas_pkg::IO_HOST_IN: begin
          if (!hostIoPrev_reg && host_io_line_in) begin
            io_reg <= scas_pkg::IO_NEUTRAL;
          end
        end
        default: io_reg <= scas_pkg::IO_NEUTRAL;
      endcase
    end
  end

  // card line held low outside reception; a driven line copies the input line
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cardIoOut <= 1'b0;
      cardIoOe <= 1'b1;
      host_io_line_out <= 1'b1;
      host_io_line_oe <= 1'b0;
    end else begin
      cardIoOut <= ioRx_reg && host_io_line_in;
      cardIoOe <= !ioRx_reg || io_reg == scas_pkg::IO_HOST_IN;
      host_io_line_out <= cardIoIn;
      host_io_line_oe <= ioRx_reg && io_reg == scas_pkg::IO_CARD_IN;
    end
  end
endmodule : scas_sequencer

/* File: sim/scas_host_model.sv */
// host controller model: request, host reset, oscillator and host I/O line
// assumes a free running system clock
`timescale 1ns/1ps
module scas_host_model (
  input wire logic clock,
  input wire logic host_io_line_out,
  input wire logic host_io_line_oe,
  output logic osc_input,
  output logic card_power_request_n,
  output logic host_reset_in,
  output logic host_io_line_in
);
  logic hostDrv = 1'b1;
  logic [1:0] oscCnt = 2'h0;
  initial begin
    card_power_request_n = 1'b1;
    host_reset_in = 1'b0;
  end
  // a quarter of the system rate keeps the sampled oscillator legal
  always @(negedge clock) oscCnt <= oscCnt + 2'h1;
  assign osc_input = oscCnt[1];
  // released line sits at its pull-up level
  assign host_io_line_in = host_io_line_oe ? host_io_line_out : hostDrv;
  task automatic set_req(input logic v);
    @(negedge clock);
    card_power_request_n = v;
  endtask : set_req
  task automatic set_rst(input logic v);
    @(negedge clock);
    host_reset_in = v;
  endtask : set_rst
  task automatic set_host(input logic v);
    @(negedge clock);
    hostDrv = v;
  endtask : set_host
endmodule : scas_host_model

/* File: sim/scas_sequencer_chk.sv */
// port checker for the sequencer
// assumes one clock and rst_n async active low
`timescale 1ns/1ps
module scas_sequencer_chk #(
  parameter int unsigned POWERUP_WAIT_CYCLES = 50
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic card_power_request_n,
  input wire logic host_reset_in,
  input wire logic card_voltage_select,
  input wire logic cardPresent,
  input wire logic logicSupplyOk,
  input wire logic overCurrent,
  input wire logic statusIntNOut,
  input wire logic statusIntNOe,
  input wire logic cardSupplyEn,
  input wire logic cardSupply5v,
  input wire logic cardClock,
  input wire logic cardReset
);
  logic [16:0] upCnt_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) upCnt_reg <= 17'h0;
    else if (!logicSupplyOk) upCnt_reg <= 17'h0;
    else if (upCnt_reg != 17'h1FFFF) upCnt_reg <= upCnt_reg + 17'h1;
  end
  holdoff_guard_a: assert property ($rose(cardSupplyEn) |-> upCnt_reg > POWERUP_WAIT_CYCLES)
    else $error("supply on during hold-off");
  start_answer_a: assert property ((upCnt_reg > POWERUP_WAIT_CYCLES + 2) && $fell(card_power_request_n)
    && cardPresent && logicSupplyOk && !overCurrent && !cardSupplyEn && !$past(cardSupplyEn, 2) |=> cardSupplyEn)
    else $error("request not answered");
  volt_pick_a: assert property ($rose(cardSupplyEn) |-> cardSupply5v == $past(card_voltage_select))
    else $error("wrong supply level");
  status_idle_a: assert property ($past(rst_n) && card_power_request_n && $past(card_power_request_n)
    && !cardSupplyEn && !$past(cardSupplyEn) |-> statusIntNOe == !$past(cardPresent))
    else $error("idle status not presence");
  open_drain_a: assert property (statusIntNOut == 1'b0)
    else $error("status pin driven high");
  // fault latch then status register: the pin answers two cycles after the fault is seen
  fault_flag_a: assert property (!card_power_request_n && !$past(card_power_request_n) && cardSupplyEn
    && (!cardPresent || overCurrent || !logicSupplyOk) |-> ##2 statusIntNOe)
    else $error("fault not reported");
  fault_report_a: assert property ($fell(cardSupplyEn) && !card_power_request_n |=> statusIntNOe)
    else $error("supply dropped silently");
  deact_bound_a: assert property (cardSupplyEn && (card_power_request_n || !cardPresent || overCurrent
    || !logicSupplyOk) |-> ##[1:400] !cardSupplyEn)
    else $error("deactivation too slow");
  quiet_off_a: assert property (!cardSupplyEn |-> !cardClock && !cardReset)
    else $error("card lines live without supply");
  rst_copy_a: assert property (cardReset |-> $past(host_reset_in))
    else $error("card reset not a host copy");
endmodule : scas_sequencer_chk
bind scas_sequencer scas_sequencer_chk #(.POWERUP_WAIT_CYCLES(POWERUP_WAIT_CYCLES)) i_chk (.clock, .rst_n,
  .card_power_request_n, .host_reset_in, .card_voltage_select, .cardPresent, .logicSupplyOk, .overCurrent,
  .statusIntNOut, .statusIntNOe, .cardSupplyEn, .cardSupply5v, .cardClock, .cardReset);

/* File: sim/test_smart_card_activation_sequencer.sv */
// self-checking bench for the card activation sequencer
// assumes the host model drives request, host reset, oscillator and host line
`timescale 1ns/1ps
module test_smart_card_activation_sequencer;
  logic clock = 1'b0;
  logic rst_n;
  logic card_voltage_select, clock_ratio_sel_hi, clock_ratio_sel_lo;
  logic cardPresent, logicSupplyOk, cardSupplyValid, overCurrent;
  // card end of the I/O line; released, it sits at its pull-up level
  logic cardDrv;
  logic cardIoIn, cardIoOut, cardIoOe, host_io_line_in, host_io_line_out, host_io_line_oe;
  logic statusIntNOut, statusIntNOe, cardSupplyEn, cardSupply5v, cardClock, cardReset;
  logic card_power_request_n, host_reset_in, osc_input;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int t, t2;
  initial forever #50 clock = ~clock;
  assign cardIoIn = cardIoOe ? cardIoOut : cardDrv;
  scas_host_model i_host (.clock, .host_io_line_out, .host_io_line_oe, .osc_input, .card_power_request_n,
    .host_reset_in, .host_io_line_in);
  scas_sequencer #(.POWERUP_WAIT_CYCLES(50)) i_dut (.clock, .rst_n, .card_power_request_n, .host_reset_in,
    .card_voltage_select, .clock_ratio_sel_hi, .clock_ratio_sel_lo, .osc_input, .cardPresent, .logicSupplyOk,
    .cardSupplyValid, .overCurrent, .cardIoIn, .cardIoOut, .cardIoOe, .host_io_line_in, .host_io_line_out,
    .host_io_line_oe, .statusIntNOut, .statusIntNOe, .cardSupplyEn, .cardSupply5v, .cardClock, .cardReset);
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk
  task automatic chk_int(input string what, input int exp, input int got);
    samples_checked++;
    if (got != exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_int
  task automatic wait_sig(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    while (s !== v && n < lim) begin
      @(negedge clock);
      n++;
    end
    chk("wait level", v, s);
  endtask : wait_sig
  function automatic int div_of(input logic [1:0] r);
    case (r)
      scas_pkg::RATIO_DIV6: return 6;
      scas_pkg::RATIO_DIV4: return 4;
      scas_pkg::RATIO_DIV1: return 1;
      default: return 2;
    endcase
  endfunction : div_of
  task automatic activate(input logic hr);
    i_host.set_rst(hr);
    card_voltage_select = 1'($urandom_range(1));
    i_host.set_req(1'b0);
    repeat (2) @(negedge clock);
    chk("supply on", 1'b1, cardSupplyEn);
    chk("supply level", card_voltage_select, cardSupply5v);
  endtask : activate
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'h3aae));
    rst_n = 1'b0;
    {cardPresent, logicSupplyOk, cardSupplyValid, overCurrent, cardDrv} = 5'h1D;
    {card_voltage_select, clock_ratio_sel_hi, clock_ratio_sel_lo} = 3'($urandom);
    repeat (5) @(negedge clock);
    rst_n = 1'b1;
    i_host.set_req(1'b0);
    repeat (10) @(negedge clock);
    chk("hold-off", 1'b0, cardSupplyEn);
    i_host.set_req(1'b1);
    repeat (6) begin
      cardPresent = 1'($urandom_range(1));
      repeat (2) @(negedge clock);
      chk("presence status", !cardPresent, statusIntNOe);
    end
    cardPresent = 1'b1;
    repeat (60) @(negedge clock);
    $display("test idle done");
    for (int r = 0; r < 4; r++) begin
      {clock_ratio_sel_hi, clock_ratio_sel_lo} = 2'(r);
      activate(1'b0);
      wait_sig(cardClock, 1'b1, 400, t);
      chk("io reception", 1'b0, cardIoOe);
      wait_sig(cardClock, 1'b0, 40, t);
      wait_sig(cardClock, 1'b1, 40, t2);
      chk_int("card clock period", 4 * div_of(2'(r)), t + t2);
      i_host.set_host(1'b0);
      repeat (3) @(negedge clock);
      chk("card line driven", 1'b1, cardIoOe & ~cardIoOut);
      i_host.set_host(1'b1);
      repeat (3) @(negedge clock);
      chk("lines neutral", 1'b0, cardIoOe | host_io_line_oe);
      cardDrv = 1'b0;
      repeat (3) @(negedge clock);
      chk("host line driven", 1'b1, host_io_line_oe & ~host_io_line_out);
      cardDrv = 1'b1;
      repeat (3) @(negedge clock);
      chk("lines neutral after card", 1'b0, cardIoOe | host_io_line_oe);
      i_host.set_rst(1'b1);
      repeat (3) @(negedge clock);
      chk("reset follows", 1'b1, cardReset);
      i_host.set_req(1'b1);
      wait_sig(cardReset, 1'b0, 100, t);
      // the first step must wait a whole interval, less at most one oscillator period of phase
      chk("full first interval", 1'b1, t >= 4 * scas_pkg::INTERVAL_TICKS - 4);
      wait_sig(cardIoOe, 1'b1, 300, t);
      chk_int("reset to io gap", 8 * scas_pkg::INTERVAL_TICKS, t);
      chk("clock stopped", 1'b0, cardClock);
      wait_sig(cardSupplyEn, 1'b0, 300, t);
      // io enable is registered one cycle behind its step, supply enable is not
      chk_int("io to supply gap", 4 * scas_pkg::INTERVAL_TICKS - 1, t);
      $display("test ratio %0d done", r);
    end
    for (int k = 0; k < 3; k++) begin
      activate(1'b1);
      repeat (200) @(negedge clock);
      chk("clock held", 1'b0, cardClock | cardReset);
      i_host.set_rst(1'b0);
      wait_sig(cardClock, 1'b1, 100, t);
      if (k == 0) cardPresent = 1'b0;
      if (k == 1) overCurrent = 1'b1;
      if (k == 2) logicSupplyOk = 1'b0;
      repeat (2) @(negedge clock);
      chk("fault status", 1'b1, statusIntNOe);
      wait_sig(cardSupplyEn, 1'b0, 400, t);
      cardPresent = 1'b1;
      overCurrent = 1'b0;
      logicSupplyOk = 1'b1;
      repeat (100) @(negedge clock);
      i_host.set_req(1'b1);
      repeat (2) @(negedge clock);
      chk("status cleared", 1'b0, statusIntNOe);
      $display("test fault %0d done", k);
    end
    cardSupplyValid = 1'b0;
    activate(1'b0);
    wait_sig(cardSupplyEn, 1'b0, 100, t);
    // the status register follows the fault latch one cycle later
    @(negedge clock);
    chk("supply fault status", 1'b1, statusIntNOe);
    cardSupplyValid = 1'b1;
    i_host.set_req(1'b1);
    repeat (2) @(negedge clock);
    $display("test supply check done");
    wrap_up();
  end
endmodule : test_smart_card_activation_sequencer
